/* File: common/fil_consts.svh */
// timing counts and codes for the fault indication and log block
`ifndef FIL_CONSTS_SVH
`define FIL_CONSTS_SVH
// clock rate in hertz
`define FIL_CLK_HZ 25000000
// lamp flash rate in hertz
`define FIL_FLASH_HZ 2
// dark pause between bursts in seconds
`define FIL_PAUSE_S 2
// half period of the 2 Hz flash, in cycles
`define FIL_HALF_CYC (`FIL_CLK_HZ / (2 * `FIL_FLASH_HZ))
// number of half periods in the pause
`define FIL_PAUSE_HALVES (2 * `FIL_FLASH_HZ * `FIL_PAUSE_S)
// power-up self check length in half periods
`define FIL_CHECK_HALVES 4
// fault codes, equal to pulse count per burst
`define FIL_CODE_NONE 3'h0
`define FIL_CODE_OVERLOAD 3'h1
`define FIL_CODE_EXTERNAL 3'h2
`define FIL_CODE_OVERVOLT 3'h3
`define FIL_CODE_OVERCUR 3'h4
`define FIL_CODE_OVERTEMP 3'h5
// history depth and keypad view depth
`define FIL_HIST_DEPTH 4
`endif

/* File: common/fil_pkg.sv */
// types shared by the fault indication and log block
package fil_pkg;
    // monitor inputs, one bit per fault source
    typedef struct packed {
        logic overload;
        logic external;
        logic overvolt;
        logic overcur;
        logic overtemp;
    } fil_monitor_type;
    // the three indicator lamps
    typedef struct packed {
        logic run;
        logic status;
        logic pattern;
    } fil_lamps_type;
    // acknowledge sources
    typedef struct packed {
        logic forward_run_command;
        logic reverse_run_command;
        logic drive_enable_input;
        logic stop_key;
        logic serial_reset;
    } fil_ack_type;
endpackage

/* File: verilog/fil_core.sv */
// fault supervision, lamp indication and fault history
//
// Contract
// - fault stops motor and opens relay
// - fault: status lamp steady, pattern flashes
// - pulses at 2 Hz, two second pause
// - pulse count one to five per fault
// - undervoltage: run off, reds flash together
// - power-up: reds flash, check, then run
// - processor fault: reds steady, latched forever
// - no auto restart; needs fault reset
// - enable level suffices, no edge needed
// - reset by power, enable toggle, stop, serial
// - history newest first, in occurrence order
// - history never cleared, survives defaults
// - keypad sees four newest entries only
// - decimal points mark entry age
`timescale 1ns/1ps
`default_nettype none
`include "fil_consts.svh"
module fil_core
    import fil_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fil_monitor_type monitor,
    input wire logic mains_low,
    input wire logic cpu_fault,
    input wire fil_ack_type ack,
    input wire logic browse_start,
    input wire logic up_key,
    output fil_lamps_type lamps,
    output logic motor_run,
    output logic relay_closed,
    output logic [2:0] shown_code,
    output logic [2:0] shown_points,
    output logic points_on
);
    // ****************************************
    // flash timebase
    // ****************************************
    localparam int HALF = `FIL_HALF_CYC;
    logic [23:0] div; // divides clock down to half periods
    logic [23:0] next_div;
    logic tick; // one-cycle pulse each half period
    logic phase; // flash phase, high = lit
    logic next_phase;
    always_comb
    begin
        tick = (div == 24'(HALF - 1));
        next_div = tick ? 24'h000000 : div + 24'h000001;
        next_phase = tick ? ~phase : phase;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div <= 24'h000000;
            phase <= 1'b0;
        end
        else
        begin
            div <= next_div;
            phase <= next_phase;
        end
    end

    // ****************************************
    // fault detect and latch
    // ****************************************
    logic [2:0] raw_code; // highest numbered active monitor
    logic [2:0] code; // latched fault code
    logic [2:0] next_code;
    logic cpu_latched; // processor fault, cleared only by rst
    logic next_cpu;
    logic en_level; // any run or enable level
    logic en_prev;
    logic ack_req; // an acknowledge event this cycle
    logic checking; // power-up check in progress
    logic [2:0] check_cnt;
    logic [2:0] next_check_cnt;
    logic new_fault; // a fresh fault enters the latch
    always_comb
    begin
        raw_code = `FIL_CODE_NONE;
        if (monitor.overload)
            raw_code = `FIL_CODE_OVERLOAD;
        if (monitor.external)
            raw_code = `FIL_CODE_EXTERNAL;
        if (monitor.overvolt)
            raw_code = `FIL_CODE_OVERVOLT;
        if (monitor.overcur)
            raw_code = `FIL_CODE_OVERCUR;
        if (monitor.overtemp)
            raw_code = `FIL_CODE_OVERTEMP;
        en_level = ack.forward_run_command | ack.reverse_run_command
            | ack.drive_enable_input;
        // enable re-applied, stop key or serial reset
        ack_req = (en_level & ~en_prev) | ack.stop_key | ack.serial_reset;
        new_fault = (code == `FIL_CODE_NONE) && (raw_code != `FIL_CODE_NONE);
        next_code = code;
        if (ack_req && raw_code == `FIL_CODE_NONE)
            next_code = `FIL_CODE_NONE;
        // latch holds until acknowledged, set wins
        if (new_fault)
            next_code = raw_code;
        next_cpu = cpu_latched | cpu_fault;
        // check lasts a few half periods after power-up or mains back
        next_check_cnt = check_cnt;
        if (mains_low)
            next_check_cnt = 3'(`FIL_CHECK_HALVES);
        else if (tick && check_cnt != 3'h0)
            next_check_cnt = check_cnt - 3'h1;
        checking = (check_cnt != 3'h0);
    end
    always_ff @(posedge clk)
    begin
        // power cycle is modelled by rst, which clears the latch
        if (rst)
        begin
            code <= `FIL_CODE_NONE;
            cpu_latched <= 1'b0;
            // starts high so a held enable makes no false edge after reset
            en_prev <= 1'b1;
            check_cnt <= 3'(`FIL_CHECK_HALVES);
        end
        else
        begin
            code <= next_code;
            cpu_latched <= next_cpu;
            en_prev <= en_level;
            check_cnt <= next_check_cnt;
        end
    end

    // ****************************************
    // pulse burst generator
    // ****************************************
    typedef enum logic [0:0] {BURST, PAUSE} fil_burst_type;
    fil_burst_type bstate;
    fil_burst_type next_bstate;
    logic [3:0] bcnt; // half periods done in this stage
    logic [3:0] next_bcnt;
    logic pattern_lit; // pattern lamp during a fault
    always_comb
    begin
        next_bstate = bstate;
        next_bcnt = bcnt;
        pattern_lit = 1'b0;
        unique case (bstate)
            BURST:
            begin
                // lit on even half periods, dark on odd ones
                pattern_lit = ~bcnt[0];
                if (tick)
                begin
                    if (bcnt == {code, 1'b0} - 4'h1)
                    begin
                        next_bstate = PAUSE;
                        next_bcnt = 4'h0;
                    end
                    else
                        next_bcnt = bcnt + 4'h1;
                end
            end
            PAUSE:
            begin
                if (tick)
                begin
                    if (bcnt == 4'(`FIL_PAUSE_HALVES - 1))
                    begin
                        next_bstate = BURST;
                        next_bcnt = 4'h0;
                    end
                    else
                        next_bcnt = bcnt + 4'h1;
                end
            end
        endcase
        // restart the pattern cleanly at each new fault
        if (code == `FIL_CODE_NONE)
        begin
            next_bstate = BURST;
            next_bcnt = 4'h0;
            pattern_lit = 1'b0;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bstate <= BURST;
            bcnt <= 4'h0;
        end
        else
        begin
            bstate <= next_bstate;
            bcnt <= next_bcnt;
        end
    end

    // ****************************************
    // lamps, motor and relay
    // ****************************************
    fil_lamps_type next_lamps;
    logic next_run;
    always_comb
    begin
        next_run = 1'b0;
        if (cpu_latched)
            next_lamps = '{run: 1'b0, status: 1'b1, pattern: 1'b1};
        else if (mains_low || checking)
            // reds flash in step; also during check
            next_lamps = '{run: 1'b0, status: phase, pattern: phase};
        else if (code != `FIL_CODE_NONE)
            next_lamps = '{run: 1'b0, status: 1'b1, pattern: pattern_lit};
        else
        begin
            // enable level alone runs the motor
            next_run = en_level;
            // run lamp flashes once check is done
            next_lamps = '{run: phase, status: 1'b0, pattern: 1'b0};
        end
    end
    always_ff @(posedge clk)
    begin
        // any fault drops motor and relay
        if (rst)
        begin
            lamps <= '{run: 1'b0, status: 1'b0, pattern: 1'b0};
            motor_run <= 1'b0;
            relay_closed <= 1'b0;
        end
        else
        begin
            lamps <= next_lamps;
            motor_run <= next_run;
            relay_closed <= ~(cpu_latched | (code != `FIL_CODE_NONE));
        end
    end

    // ****************************************
    // fault history and keypad view
    // ****************************************
    // history has no reset: it is never cleared and survives defaults
    logic [2:0] hist [`FIL_HIST_DEPTH];
    logic [2:0] next_hist [`FIL_HIST_DEPTH];
    logic [1:0] view; // 0 = newest entry
    logic [1:0] next_view;
    always_comb
    begin
        // shift in newest at the head
        next_hist[0] = new_fault ? raw_code : hist[0];
        for (int i = 1; i < `FIL_HIST_DEPTH; i++)
            next_hist[i] = new_fault ? hist[i-1] : hist[i];
        // OK selects history, UP steps older
        next_view = view;
        if (browse_start)
            next_view = 2'h0;
        else if (up_key && view != 2'h3)
            next_view = view + 2'h1;
    end
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < `FIL_HIST_DEPTH; i++)
            hist[i] <= next_hist[i];
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            view <= 2'h0;
            shown_code <= 3'h0;
            shown_points <= 3'h0;
            points_on <= 1'b0;
        end
        else
        begin
            view <= next_view;
            shown_code <= hist[view];
            // count of rightmost points equals entry age
            shown_points <= (view == 2'h0) ? 3'h0 :
                (view == 2'h1) ? 3'h1 : (view == 2'h2) ? 3'h3 : 3'h7;
            points_on <= phase;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    relay_open_a: assert property (@(posedge clk) disable iff (rst)
        (code != `FIL_CODE_NONE) |=> !relay_closed && !motor_run)
        else $error("relay closed while fault latched");
    status_steady_a: assert property (@(posedge clk) disable iff (rst)
        (code != 3'h0 && !cpu_latched && !mains_low && !checking)
        |=> lamps.status)
        else $error("status lamp dark during fault");
    // watch the lamp itself, not the burst decoder behind it
    sequence pause_s;
        (bstate == PAUSE && code != 3'h0 && !cpu_latched && !mains_low
        && !checking) [*2];
    endsequence
    pause_dark_a: assert property (@(posedge clk) disable iff (rst)
        pause_s |=> !lamps.pattern)
        else $error("pattern lit during pause");
    burst_len_a: assert property (@(posedge clk) disable iff (rst)
        (bstate == BURST && code != 3'h0) |-> bcnt < {code, 1'b0})
        else $error("burst longer than fault code");
    under_sync_a: assert property (@(posedge clk) disable iff (rst)
        (mains_low && !cpu_latched) |=> !lamps.run
        && lamps.status == lamps.pattern)
        else $error("red lamps out of step on undervoltage");
    cpu_hold_a: assert property (@(posedge clk) disable iff (rst)
        cpu_latched |=> cpu_latched && lamps.status && lamps.pattern)
        else $error("processor fault indication lost");
    no_restart_a: assert property (@(posedge clk) disable iff (rst)
        (code != 3'h0 && !ack_req) |=> code == $past(code))
        else $error("fault cleared without reset");
    ack_guard_a: assert property (@(posedge clk) disable iff (rst)
        (code != 3'h0 && raw_code != 3'h0) |=> code != 3'h0)
        else $error("fault cleared while condition present");
endmodule
`default_nettype wire

/* File: verif/fil_operator.sv */
// operator model: acknowledge inputs and keypad keys
`timescale 1ns/1ps
`default_nettype none
module fil_operator
    import fil_pkg::*;
(
    input wire logic clk,
    output fil_ack_type ack,
    output logic browse_start,
    output logic up_key
);
    // ********************************
    // idle levels and key pulses
    // ********************************
    // enable stays high from time zero; the device needs no edge
    // level enable
    initial
    begin
        ack = '0;
        ack.drive_enable_input = 1'b1;
        browse_start = 1'b0;
        up_key = 1'b0;
    end
    // one-cycle action: 0 stop, 1 serial, 2 enable off/on, 3 browse, 4 up
    // ack and browse
    task automatic press(input int kind);
        @(posedge clk);
        case (kind)
            0: ack.stop_key <= 1'b1;
            1: ack.serial_reset <= 1'b1;
            2: ack.drive_enable_input <= 1'b0;
            3: browse_start <= 1'b1;
            default: up_key <= 1'b1;
        endcase
        @(posedge clk);
        ack.stop_key <= 1'b0;
        ack.serial_reset <= 1'b0;
        ack.drive_enable_input <= 1'b1;
        browse_start <= 1'b0;
        up_key <= 1'b0;
        // let the release land before the next request
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: verif/fault_indication_and_log_test.sv */
// self-checking bench for the fault indication and log block
`timescale 1ns/1ps
`default_nettype none
module fault_indication_and_log_test;
    import fil_pkg::*;
    // ********************************
    // signals and instances
    // ********************************
    logic clk, rst, mains_low, cpu_fault, browse_start, up_key;
    logic motor_run, relay_closed, points_on;
    fil_monitor_type monitor;
    fil_ack_type ack;
    fil_lamps_type lamps;
    logic [2:0] shown_code, shown_points;
    int n_mismatch, checks;
    fil_core dut (.clk(clk), .rst(rst), .monitor(monitor),
        .mains_low(mains_low), .cpu_fault(cpu_fault), .ack(ack),
        .browse_start(browse_start), .up_key(up_key), .lamps(lamps),
        .motor_run(motor_run), .relay_closed(relay_closed),
        .shown_code(shown_code), .shown_points(shown_points),
        .points_on(points_on));
    fil_operator op (.clk(clk), .ack(ack), .browse_start(browse_start),
        .up_key(up_key));
    // ********************************
    // shared tasks
    // ********************************
    task automatic results;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want,
        input string msg);
        checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // bounded wait for the relay; a hang ends the run
    task automatic wait_relay(input logic want);
        int i;
        for (i = 0; i < 8 && relay_closed !== want; i++)
        begin
            @(posedge clk);
            #1;
        end
        check(relay_closed, want, "relay timeout");
        if (relay_closed !== want)
            results();
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_start;
        wait_relay(1'b1);
        check(lamps.run, 1'b0, "run lamp during check");
        check(lamps.status, lamps.pattern, "reds not in step");
    endtask
    // latch each code, refuse early ack, no auto restart, then clear
    task automatic t_fault(input int c);
        @(posedge clk);
        monitor <= fil_monitor_type'(5'h10 >> (c - 1));
        wait_relay(1'b0);
        check(motor_run, 1'b0, "motor still runs");
        op.press(0);
        check(relay_closed, 1'b0, "ack taken while active");
        monitor <= '0;
        repeat (4) @(posedge clk);
        #1;
        check(relay_closed, 1'b0, "auto restart");
        op.press(c % 3);
        wait_relay(1'b1);
    endtask
    // newest first, four entries, points mark the age
    // want packs the four newest codes, newest in the top three bits
    task automatic t_history(input logic [11:0] want);
        logic [2:0] pts [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        int i;
        int k;
        op.press(3);
        for (i = 0; i < 5; i++)
        begin
            if (i > 0)
                op.press(4);
            #1;
            k = (i > 3) ? 3 : i;
            check(shown_code, want[3 * (3 - k) +: 3], "entry");
            check(shown_points, pts[k], "points");
        end
        check(points_on, 1'b0, "points lit in first half period");
    endtask
    // power cycle clears a latched fault; history survives
    task automatic t_power;
        @(posedge clk);
        monitor <= fil_monitor_type'(5'h02);
        wait_relay(1'b0);
        @(posedge clk);
        monitor <= '0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        wait_relay(1'b1);
        t_history({3'h4, 3'h5, 3'h4, 3'h3});
    endtask
    task automatic t_mains;
        @(posedge clk);
        mains_low <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(lamps.run, 1'b0, "run lamp on undervoltage");
        check(lamps.status, lamps.pattern, "reds apart");
        @(posedge clk);
        mains_low <= 1'b0;
    endtask
    // processor fault lights both reds and never recovers
    task automatic t_cpu;
        @(posedge clk);
        cpu_fault <= 1'b1;
        @(posedge clk);
        cpu_fault <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(lamps, 3'h3, "cpu fault lamps");
        check(relay_closed, 1'b0, "relay closed on cpu fault");
        op.press(0);
        op.press(1);
        check(lamps, 3'h3, "cpu fault cleared");
    endtask
    // ********************************
    // clock and main sequence
    // ********************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        n_mismatch = 0;
        checks = 0;
        rst = 1'b1;
        monitor = '0;
        mains_low = 1'b0;
        cpu_fault = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_start();
        for (int c = 1; c <= 5; c++)
            t_fault(c);
        t_history({3'h5, 3'h4, 3'h3, 3'h2});
        t_power();
        t_mains();
        t_cpu();
        results();
    end
endmodule
`default_nettype wire
